// ==== src/irq_bank_regs.svh ====
// Register map, field positions and reset values of the peripheral
// interrupt enable bank. Definitions only; included by bare name.
`ifndef IRQ_BANK_REGS_SVH
`define IRQ_BANK_REGS_SVH

// ---------------------------------------------------------------------------
// Byte offsets
// ---------------------------------------------------------------------------
`define OFS_ENABLE_A 8'h00
`define OFS_ENABLE_B 8'h04
`define OFS_ENABLE_C 8'h08
`define OFS_CORE_CTRL 8'h0C
`define OFS_FLAG_A 8'h10
`define OFS_FLAG_B 8'h14
`define OFS_FLAG_C 8'h18

// ---------------------------------------------------------------------------
// Fields
// ---------------------------------------------------------------------------
`define BIT_GLOBAL_EN 7
`define BIT_MASTER_EN 6
`define BIT_TIMER1_GATE 7
`define BIT_ADC_DONE 6
`define BIT_SERIAL1_RX 5
`define BIT_SERIAL1_TX 4
`define BIT_SYNCSER1 3
`define BIT_CAPCMP1 2
`define BIT_TIMER2_MATCH 1
`define BIT_TIMER1_OVF 0
`define BIT_OSC_FAIL 7
`define BIT_TIMER5_GATE 6
`define BIT_TIMER3_GATE 5
`define BIT_B_UNUSED 4
`define BIT_SYNCSER1_COLL 3
`define BIT_TIMER10_MATCH 2
`define BIT_TIMER8_MATCH 1
`define BIT_CAPCMP2 0
`define IMPL_MASK_A 8'hFF
`define IMPL_MASK_B 8'hEF
`define IMPL_MASK_C 8'hFF

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define RST_ENABLE 8'h00
`define RST_FLAG 8'h00
`define RST_CORE_CTRL 8'h00

`endif

// ==== src/irq_bank_pkg.sv ====
// Types shared by the enable bank, its flag store and their interface.
// Assumes the register header is on the include path.
package irq_bank_pkg;
  // Three 8-bit registers, index 0 is bank A.
  typedef logic [2:0][7:0] bank_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_t;
  typedef enum logic [2:0] {
    SEL_ENABLE_A = 3'b000,
    SEL_ENABLE_B = 3'b001,
    SEL_ENABLE_C = 3'b010,
    SEL_CORE_CTRL = 3'b011,
    SEL_FLAG_A = 3'b100,
    SEL_FLAG_B = 3'b101,
    SEL_FLAG_C = 3'b110,
    SEL_NONE = 3'b111
  } reg_sel_t;
endpackage

// ==== src/irq_bank_if.sv ====
// Carrier between the register front end and the sticky flag store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface irq_bank_if;
  import irq_bank_pkg::*;
  bank_t enable;
  bank_t clear;
  bank_t event_in;
  bank_t flag;
  logic pending;
  modport ctrl (output enable, output clear, output event_in,
                input flag, input pending);
  modport bank (input enable, input clear, input event_in,
                output flag, output pending);
endinterface
`default_nettype wire

// ==== src/irq_flag_bank.sv ====
// Sticky peripheral interrupt flags and the enabled-pending reduction.
// Assumes event pulses and clears come from logic on hclk.
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_regs.svh"
module irq_flag_bank (
  input wire logic hclk,
  input wire logic hresetn,
  irq_bank_if.bank bus
);
  import irq_bank_pkg::*;

  localparam bank_t IMPL = {`IMPL_MASK_C, `IMPL_MASK_B, `IMPL_MASK_A};

  bank_t flag_reg;

  // -------------------------------------------------------------------------
  // Flags
  // -------------------------------------------------------------------------
  // An event in the cycle of a clear keeps the flag set, so no event is lost.
  genvar r;
  generate
    for (r = 0; r < 3; r++) begin : g_flag
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flag_reg[r] <= `RST_FLAG;
        end else begin
          flag_reg[r] <= ((flag_reg[r] & ~bus.clear[r]) | bus.event_in[r])
                         & IMPL[r];
        end
      end
    end
  endgenerate

  assign bus.flag = flag_reg;
  assign bus.pending = |(flag_reg & bus.enable);

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  flag_on_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (bus.event_in[0] != 8'h00) |=> ((flag_reg[0] & $past(bus.event_in[0]))
      == $past(bus.event_in[0])))
    else $error("event did not set its flag");

  flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (bus.clear[2] != 8'h00) |=> ((flag_reg[2] & $past(bus.clear[2]))
      == ($past(bus.event_in[2]) & $past(bus.clear[2]))))
    else $error("write one did not clear a flag");

  cover_set_clear_c: cover property (@(posedge hclk) disable iff (!hresetn)
    (bus.clear[0] & bus.event_in[0]) != 8'h00);
endmodule // irq_flag_bank
`default_nettype wire

// ==== src/periph_irq_enable_bank.sv ====
// AHB-Lite register front end of the peripheral interrupt enable bank.
// Assumes one AHB-Lite master, word transfers, events as hclk pulses.
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_regs.svh"
module periph_irq_enable_bank #(
  parameter int NUM_BANKS = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] periph_event_a,
  input wire logic [7:0] periph_event_b,
  input wire logic [7:0] periph_event_c,
  output logic periph_irq_req
);
  import irq_bank_pkg::*;

  // -------------------------------------------------------------------------
  // Elaboration check
  // -------------------------------------------------------------------------
  generate
    if (NUM_BANKS != 3) begin : g_bad_banks
      $error("only three enable registers are supported");
    end
  endgenerate

  localparam bank_t IMPL = {`IMPL_MASK_C, `IMPL_MASK_B, `IMPL_MASK_A};
  localparam logic [7:0] CTRL_RST = `RST_CORE_CTRL;

  irq_bank_if bank_bus ();

  bus_state_t state_reg;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  bank_t enable_reg;
  bank_t clear_next;
  logic global_en_reg;
  logic master_en_reg;
  logic irq_reg;
  logic accept;
  logic wr_phase;
  reg_sel_t wr_sel;

  // -------------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------------
  function automatic reg_sel_t decode(input logic [7:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    unique case (a)
      `OFS_ENABLE_A: s = SEL_ENABLE_A;
      `OFS_ENABLE_B: s = SEL_ENABLE_B;
      `OFS_ENABLE_C: s = SEL_ENABLE_C;
      `OFS_CORE_CTRL: s = SEL_CORE_CTRL;
      `OFS_FLAG_A: s = SEL_FLAG_A;
      `OFS_FLAG_B: s = SEL_FLAG_B;
      `OFS_FLAG_C: s = SEL_FLAG_C;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction

  function automatic logic [31:0] read_value(input reg_sel_t s,
                                             input bank_t en,
                                             input bank_t fl,
                                             input logic ge,
                                             input logic me);
    logic [7:0] v;
    v = 8'h00;
    unique case (s)
      SEL_ENABLE_A: v = en[0];
      SEL_ENABLE_B: v = en[1] & `IMPL_MASK_B;
      SEL_ENABLE_C: v = en[2];
      SEL_CORE_CTRL: begin
        v[`BIT_GLOBAL_EN] = ge;
        v[`BIT_MASTER_EN] = me;
      end
      SEL_FLAG_A: v = fl[0];
      SEL_FLAG_B: v = fl[1];
      SEL_FLAG_C: v = fl[2];
      SEL_NONE: v = 8'h00;
    endcase
    return {24'h000000, v};
  endfunction

  assign accept = hsel && hready && htrans[1];
  assign wr_phase = (state_reg == BUS_WRITE);
  assign wr_sel = decode(addr_reg);

  // -------------------------------------------------------------------------
  // Bus phases
  // -------------------------------------------------------------------------
  // Reads take one wait state so hrdata comes from a flop and always
  // reflects a write finished in the cycle before.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= BUS_IDLE;
      addr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
    end else begin
      if (accept) begin
        state_reg <= hwrite ? BUS_WRITE : BUS_READ;
        addr_reg <= haddr[7:0];
        hreadyout_reg <= hwrite;
      end else begin
        state_reg <= BUS_IDLE;
        hreadyout_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else if (state_reg == BUS_READ) begin
      hrdata_reg <= read_value(decode(addr_reg), enable_reg,
                               bank_bus.flag, global_en_reg, master_en_reg);
    end
  end

  // Every transfer answers OKAY, unmapped ones included.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_reg <= 1'b0;
    end else begin
      hresp_reg <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Enable and control registers
  // -------------------------------------------------------------------------
  genvar r;
  generate
    for (r = 0; r < 3; r++) begin : g_enable
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          enable_reg[r] <= `RST_ENABLE;
        end else if (wr_phase && wr_sel == reg_sel_t'(r)) begin
          enable_reg[r] <= hwdata[7:0] & IMPL[r];
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_en_reg <= CTRL_RST[`BIT_GLOBAL_EN];
      master_en_reg <= CTRL_RST[`BIT_MASTER_EN];
    end else if (wr_phase && wr_sel == SEL_CORE_CTRL) begin
      global_en_reg <= hwdata[`BIT_GLOBAL_EN];
      master_en_reg <= hwdata[`BIT_MASTER_EN];
    end
  end

  // Flags clear by writing one; the store lets a same-cycle event win.
  always_comb begin
    clear_next = '0;
    if (wr_phase) begin
      unique case (wr_sel)
        SEL_FLAG_A: clear_next[0] = hwdata[7:0];
        SEL_FLAG_B: clear_next[1] = hwdata[7:0];
        SEL_FLAG_C: clear_next[2] = hwdata[7:0];
        default: clear_next = '0;
      endcase
    end
  end

  assign bank_bus.enable = enable_reg;
  assign bank_bus.clear = clear_next;
  assign bank_bus.event_in = {periph_event_c, periph_event_b, periph_event_a};

  irq_flag_bank u_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .bus(bank_bus.bank)
  );

  // -------------------------------------------------------------------------
  // Core request
  // -------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= global_en_reg && master_en_reg
                 && bank_bus.pending;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign periph_irq_req = irq_reg;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  req_needs_master_a: assert property (
    periph_irq_req |-> $past(master_en_reg))
    else $error("request raised without master enable");

  req_needs_global_a: assert property (
    periph_irq_req |-> $past(global_en_reg))
    else $error("request raised without global enable");

  req_follows_pending_a: assert property (
    (global_en_reg && master_en_reg && bank_bus.pending) |=> periph_irq_req)
    else $error("enabled pending flag did not raise request");

  disabled_blocks_a: assert property (
    (bank_bus.flag[0] != 8'h00 && enable_reg == '0) |=> !periph_irq_req)
    else $error("source requested with all enables clear");

  enable_write_a: assert property (
    (wr_phase && wr_sel == SEL_ENABLE_C)
      |=> enable_reg[2] == $past(hwdata[7:0]))
    else $error("enable register did not take written value");

  unused_bit_zero_a: assert property (
    (state_reg == BUS_READ && decode(addr_reg) == SEL_ENABLE_B)
      |=> hrdata[`BIT_B_UNUSED] == 1'b0 && enable_reg[1][`BIT_B_UNUSED] == 1'b0)
    else $error("unimplemented enable bit read back as one");

  read_wait_a: assert property (
    (accept && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");

  read_back_a: assert property (
    (wr_phase && wr_sel == SEL_ENABLE_A) ##1 (accept && !hwrite
      && decode(haddr[7:0]) == SEL_ENABLE_A)
      |-> ##2 hrdata[7:0] == $past(enable_reg[0], 1))
    else $error("enable A did not read back");

  resp_okay_a: assert property (!hresp)
    else $error("slave answered with an error");

  // -------------------------------------------------------------------------
  // Register and gating checks
  // -------------------------------------------------------------------------
  // Each enable must block on its own, so a fault in one gate cannot hide
  // behind the other; the request register adds one edge of delay.
  master_blocks_a: assert property (
    !master_en_reg |=> !periph_irq_req)
    else $error("request raised while master enable clear");

  global_blocks_a: assert property (
    !global_en_reg |=> !periph_irq_req)
    else $error("request raised while global enable clear");

  req_drops_a: assert property (
    !bank_bus.pending |=> !periph_irq_req)
    else $error("request raised with no enabled flag pending");

  enable_a_write_a: assert property (
    (wr_phase && wr_sel == SEL_ENABLE_A)
      |=> enable_reg[0] == $past(hwdata[7:0]))
    else $error("enable A did not take written value");

  enable_b_write_a: assert property (
    (wr_phase && wr_sel == SEL_ENABLE_B)
      |=> enable_reg[1] == ($past(hwdata[7:0]) & 8'hEF))
    else $error("enable B did not take written value");

  ctrl_write_a: assert property (
    (wr_phase && wr_sel == SEL_CORE_CTRL)
      |=> global_en_reg == $past(hwdata[`BIT_GLOBAL_EN])
      && master_en_reg == $past(hwdata[`BIT_MASTER_EN]))
    else $error("control bits did not take written value");

  enables_hold_a: assert property (
    !(wr_phase && wr_sel inside {SEL_ENABLE_A, SEL_ENABLE_B, SEL_ENABLE_C})
      |=> enable_reg == $past(enable_reg))
    else $error("enable register changed without a write");

  ctrl_hold_a: assert property (
    !(wr_phase && wr_sel == SEL_CORE_CTRL)
      |=> $stable(global_en_reg) && $stable(master_en_reg))
    else $error("control bits changed without a write");

  write_no_wait_a: assert property (
    (accept && hwrite) |=> hreadyout)
    else $error("write inserted a wait state");

  flag_b_unused_a: assert property (
    bank_bus.flag[1][`BIT_B_UNUSED] == 1'b0)
    else $error("unimplemented flag bit set");

  cover_read_c: cover property (accept && !hwrite ##2 hreadyout);
  cover_write_c: cover property (wr_phase && wr_sel == SEL_ENABLE_B);
  cover_irq_c: cover property ($rose(periph_irq_req));
  cover_irq_drop_c: cover property ($fell(periph_irq_req));
endmodule // periph_irq_enable_bank
`default_nettype wire

// ==== bench/periph_event_source.sv ====
// Model of the peripheral event sources that feed the enable bank.
// Assumes the bench asks for one pulse at a time, on hclk.
`timescale 1ns/1ps
`default_nettype none
module periph_event_source (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic fire,
  input wire irq_bank_pkg::bank_t pattern,
  output logic [7:0] event_a,
  output logic [7:0] event_b,
  output logic [7:0] event_c
);
  import irq_bank_pkg::*;
  // Single-cycle pulses are the shortest event, so a flag that is not
  // sticky would be missed.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {event_c, event_b, event_a} <= '0;
    end else begin
      {event_c, event_b, event_a} <= fire ? pattern : '0;
    end
  end
endmodule // periph_event_source
`default_nettype wire

// ==== bench/periph_irq_enable_bank_bench.sv ====
// Self-checking bench of the peripheral interrupt enable bank.
// Assumes the event source model and the register header.
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_regs.svh"
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("BAD %0t %s", $time, m); end end
module periph_irq_enable_bank_bench;
  import irq_bank_pkg::*;
  logic hclk, hresetn, hsel, hwrite, fire;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, periph_irq_req;
  wire logic hready;
  logic [7:0] ev_a, ev_b, ev_c;
  bank_t pat;
  int fails = 0;
  int compares = 0;
  assign hready = hreadyout;

  periph_irq_enable_bank #(.NUM_BANKS(3)) u_periph_irq_enable_bank (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .periph_event_a(ev_a), .periph_event_b(ev_b),
    .periph_event_c(ev_c), .periph_irq_req(periph_irq_req));
  periph_event_source u_periph_event_source (.hclk(hclk),
    .hresetn(hresetn), .fire(fire), .pattern(pat), .event_a(ev_a),
    .event_b(ev_b), .event_c(ev_c));

  // ---------------------------------------------------------------------
  // Bus and event tasks
  // ---------------------------------------------------------------------
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    `CHK(hresp, 1'b0, "response not okay")
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    `CHK(rdat, e, "read data wrong")
  endtask
  // Four edges pass before the request is looked at, one more than the three of the pulse path.
  task automatic pulse(input bank_t p);
    fire <= 1'b1;
    pat <= p;
    @(posedge hclk);
    fire <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  task automatic clear_all();
    for (int b = 0; b < 3; b++) wr(`OFS_FLAG_A + 8'(b * 4), 32'hFF);
    // The last clear lands at the write's closing edge; the request
    // register follows one edge later, so two edges pass before looking.
    repeat (2) @(posedge hclk);
    `CHK(periph_irq_req, 1'b0, "request after clear")
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset_vals();
    for (int o = 0; o < 32; o += 4) rd_chk(8'(o), 32'h0);
  endtask
  task automatic t_rw();
    for (int b = 0; b < 3; b++) begin
      wr(`OFS_ENABLE_A + 8'(b * 4), 32'hFF);
      rd_chk(`OFS_ENABLE_A + 8'(b * 4), b == 1 ? 32'hEF : 32'hFF);
      wr(`OFS_ENABLE_A + 8'(b * 4), 32'h0);
      rd_chk(`OFS_ENABLE_A + 8'(b * 4), 32'h0);
    end
    wr(8'h1C, 32'hFF);
    rd_chk(8'h1C, 32'h0);
  endtask
  task automatic t_flags();
    pulse('1);
    `CHK(periph_irq_req, 1'b0, "request with all enables off")
    rd_chk(`OFS_FLAG_A, 32'hFF);
    rd_chk(`OFS_FLAG_B, 32'hEF);
    rd_chk(`OFS_FLAG_C, 32'hFF);
    clear_all();
    rd_chk(`OFS_FLAG_A, 32'h0);
  endtask
  task automatic t_gates();
    logic [7:0] ctl [4] = '{8'h00, 8'h80, 8'h40, 8'hC0};
    wr(`OFS_ENABLE_A, 32'h01);
    pulse(bank_t'(24'h000001));
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_CORE_CTRL, {24'h0, ctl[k]});
      repeat (2) @(posedge hclk);
      `CHK(periph_irq_req, ctl[k] == 8'hC0, "master gating wrong")
    end
    wr(`OFS_CORE_CTRL, 32'h80);
    repeat (2) @(posedge hclk);
    `CHK(periph_irq_req, 1'b0, "request without master")
    wr(`OFS_CORE_CTRL, 32'hC0);
    wr(`OFS_ENABLE_A, 32'h0);
    clear_all();
  endtask
  task automatic t_each_bit();
    bank_t p;
    for (int b = 0; b < 3; b++) begin
      for (int i = 0; i < 8; i++) begin
        if (b == 1 && i == 4) continue;
        p = '0;
        p[b][i] = 1'b1;
        wr(`OFS_ENABLE_A + 8'(b * 4), {24'h0, p[b]});
        pulse(~p);
        `CHK(periph_irq_req, 1'b0, "disabled source leaked")
        pulse(p);
        `CHK(periph_irq_req, 1'b1, "enabled source silent")
        clear_all();
        wr(`OFS_ENABLE_A + 8'(b * 4), 32'h0);
      end
    end
  endtask
  task automatic t_midreset();
    wr(`OFS_ENABLE_C, 32'h5A);
    wr(`OFS_CORE_CTRL, 32'hC0);
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(`OFS_ENABLE_C, 32'h0);
    rd_chk(`OFS_CORE_CTRL, 32'h0);
  endtask

  // ---------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------
  task automatic print_verdict();
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // The whole run needs well under a thousand cycles; this span of 40000 is ample.
  initial begin
    #200000;
    fails++;
    print_verdict();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fire = 1'b0;
    pat = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    t_reset_vals();
    t_rw();
    t_flags();
    t_gates();
    t_each_bit();
    t_midreset();
    print_verdict();
  end
endmodule // periph_irq_enable_bank_bench
`default_nettype wire
